// ==== hw/bsr_pkg.sv ====
package bsr_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SS_T0_US        = 500;
	localparam int SS_T1_US        = 770;
	localparam int SS_T2_US        = 1000;
	localparam int SS_T3_US        = 2000;
	localparam int SS_T0_CYC       = SS_T0_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_T1_CYC       = SS_T1_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_T2_CYC       = SS_T2_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_T3_CYC       = SS_T3_US * 1000 / CLK_PERIOD_NS;
	localparam int RECIP_SHIFT     = 24;
	// Per-cycle fraction of the target, rounded up so the ramp never runs long
	localparam logic [31:0] SS_T0_RECIP = 32'((2**RECIP_SHIFT + SS_T0_CYC - 1) / SS_T0_CYC);
	localparam logic [31:0] SS_T1_RECIP = 32'((2**RECIP_SHIFT + SS_T1_CYC - 1) / SS_T1_CYC);
	localparam logic [31:0] SS_T2_RECIP = 32'((2**RECIP_SHIFT + SS_T2_CYC - 1) / SS_T2_CYC);
	localparam logic [31:0] SS_T3_RECIP = 32'((2**RECIP_SHIFT + SS_T3_CYC - 1) / SS_T3_CYC);
	localparam int STRAP_SETTLE_NS = 200;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SSC_STEP_NS     = 1000;
	localparam int SSC_STEP_CYC    = SSC_STEP_NS / CLK_PERIOD_NS;

	// ****************************************
	// Voltages in quarter microvolts
	// ****************************************
	localparam logic [22:0] OUTPUT_SETPOINT_CODE_BASE_Q = 23'h186A00;
	localparam logic [22:0] STEP_FINE_Q = 23'h001388;
	localparam logic [22:0] STEP_MID_Q  = 23'h002710;
	localparam logic [22:0] STEP_WIDE_Q = 23'h004E20;
	// Slew per clock: 10, 5, 1.25, 0.5 mV/us at 100 MHz
	localparam logic [22:0] SLEW_0_Q    = 23'h000190;
	localparam logic [22:0] SLEW_1_Q    = 23'h0000C8;
	localparam logic [22:0] SLEW_2_Q    = 23'h000032;
	localparam logic [22:0] SLEW_3_Q    = 23'h000014;

	// ****************************************
	// Field codes and reset values
	// ****************************************
	localparam logic [1:0] RANGE_FINE  = 2'h0;
	localparam logic [1:0] RANGE_MID   = 2'h1;
	localparam logic [1:0] RANGE_RESET = 2'h2;
	localparam logic [1:0] SS_RESET    = 2'h2;
	localparam logic [1:0] SLEW_RESET  = 2'h2;
	localparam logic [7:0] SSC_SPAN    = 8'h64;
	localparam logic [7:0] SSC_FLOOR   = 8'h9C;
	// Strap tables, index = {msb, lsb}
	localparam logic [3:0][7:0]  VSTRAP_CODE = {8'h5F, 8'h24, 8'h50, 8'h46};
	localparam logic [3:0][6:0]  VSTRAP_ADDR = {7'h46, 7'h47, 7'h44, 7'h45};
	localparam logic [3:0][11:0] FSTRAP_KHZ  = {12'h9C4, 12'hBB8, 12'h5DC, 12'h8CA};

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {st_msb, st_lsb, st_done} bsr_strap_state_t;
	typedef enum logic [1:0] {ph_init, ph_off, ph_soft, ph_run} bsr_phase_t;

	typedef struct packed {
		logic       probe_first;
		logic       probe_second;
		logic       done;
		logic [1:0] code;
	} bsr_strap_t;

	typedef struct packed {
		logic       setpoint_wr;
		logic [7:0] setpoint;
		logic       range_wr;
		logic [1:0] range;
		logic       ss_wr;
		logic [1:0] ss_sel;
		logic       slew_wr;
		logic [1:0] slew_sel;
	} bsr_host_wr_t;

	typedef struct packed {
		logic forced_pwm;
		logic power_save;
		logic dcm_allowed;
		logic sync_lock;
		logic ssc_active;
	} bsr_mode_t;

	typedef struct packed {
		bsr_strap_state_t state;
		logic [7:0]       cnt;
		logic             msb;
		logic             lsb;
	} bsr_dec_state_t;

	typedef struct packed {
		bsr_phase_t  phase;
		logic [7:0]  setpoint;
		logic [1:0]  range_prog;
		logic [1:0]  range_act;
		logic [1:0]  ss_sel;
		logic [1:0]  slew_sel;
		logic [7:0]  cap_code;
		logic [1:0]  cap_range;
		logic [1:0]  cap_ss;
		logic [22:0] ref_q;
		logic [23:0] ref_frac;
		logic [6:0]  address;
		logic [11:0] fsw_khz;
		logic        enabled_once;
		logic [7:0]  ssc_tri;
		logic        ssc_up;
		logic [7:0]  ssc_cnt;
		logic        load_line;
	} bsr_ctrl_state_t;

endpackage : bsr_pkg

// ==== hw/bsr_strap_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module bsr_strap_decoder (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Strap pin
	input  wire logic         pin_level,
	// Probe control and result
	output bsr_pkg::bsr_strap_t strap
);

	bsr_pkg::bsr_dec_state_t s_reg;
	bsr_pkg::bsr_dec_state_t s_next;

	// ****************************************
	// Two-step resistor decode
	// ****************************************
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.state)
			bsr_pkg::st_msb: begin
				if (s_reg.cnt == 8'(bsr_pkg::STRAP_SETTLE_CYC - 1)) begin
					s_next.msb   = pin_level;
					s_next.cnt   = 8'h00;
					s_next.state = bsr_pkg::st_lsb;
				end else begin
					s_next.cnt = s_reg.cnt + 8'h01;
				end
			end
			bsr_pkg::st_lsb: begin
				if (s_reg.cnt == 8'(bsr_pkg::STRAP_SETTLE_CYC - 1)) begin
					s_next.lsb   = pin_level;
					s_next.state = bsr_pkg::st_done;
				end else begin
					s_next.cnt = s_reg.cnt + 8'h01;
				end
			end
			// Result holds until the next power-up
			bsr_pkg::st_done: begin
				s_next = s_reg;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '{state: bsr_pkg::st_msb, cnt: 8'h00, msb: 1'b0, lsb: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Probes stay open while the upper bit is sampled
	assign strap.probe_first  = (s_reg.state == bsr_pkg::st_lsb) && !s_reg.msb;
	assign strap.probe_second = (s_reg.state == bsr_pkg::st_lsb) && s_reg.msb;
	assign strap.done         = (s_reg.state == bsr_pkg::st_done);
	assign strap.code         = {s_reg.msb, s_reg.lsb};

endmodule : bsr_strap_decoder

`default_nettype wire

// ==== hw/bsr_setpoint_ramp_control.sv ====
// Summary of operation
// - Soft-start duration code picks 500 us, 770 us, 1 ms, 2 ms; 1 ms default.
// - Changes during soft-start wait; ramp finishes at captured target, then moves on.
// - Discontinuous and pulse-skipping switching always allowed during the start-up ramp.
// - Frequency strap sets 1.5, 2.25, 2.5 or 3 MHz switching at initialization.
// - Strap upper bit is sampled first with both probe switches open.
// - Lower bit sampled with first probe if upper is zero, else second probe.
// - Range code gives 1.25, 2.5 or 5 mV steps; 5 mV after initialization.
// - New range takes effect only after the next setpoint write.
// - Target equals 0.4 V plus setpoint code times active step size.
// - Voltage strap gives default setpoint code and serial target address.
// - Values written while disabled apply at next enable; start-up aims straight there.
// - Setpoint changes in operation ramp at 10, 5, 1.25 or 0.5 mV/us.
// - Forced PWM when mode pin high or bit set; else power-save.
// - Valid clock on mode pin locks switching to it and forces PWM.
// - Spread spectrum sweeps frequency plus or minus 10% with triangle profile.
// - Spread spectrum only with enable bit, forced PWM and no external clock.
// - With discharge enabled, discharge on low enable, switching off, or faults.
// - No discharge after power-up until converter has been enabled once.
// - Stacked secondary uses its mode pin as switching clock input.
// - Serial access and enable release only after initialization completes.
`timescale 1ns/1ps
`default_nettype none

module bsr_setpoint_ramp_control (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Enable pin, open drain
	input  wire logic               en_pin_in,
	output logic                    en_pin_out,
	output logic                    en_pin_oe,
	// Strap pins
	input  wire logic               fstrap_level,
	output logic                    fstrap_probe_first,
	output logic                    fstrap_probe_second,
	input  wire logic               vstrap_level,
	output logic                    vstrap_probe_first,
	output logic                    vstrap_probe_second,
	// Host writes
	input  wire bsr_pkg::bsr_host_wr_t host_wr,
	// Host control bits
	input  wire logic               forced_pwm_bit,
	input  wire logic               spread_spectrum_enable,
	input  wire logic               discharge_enable,
	input  wire logic               switching_enable_bit,
	input  wire logic               load_line_enable,
	// Pin and fault conditions
	input  wire logic               mode_pin_level,
	input  wire logic               sync_clock_valid,
	input  wire logic               stacked_secondary,
	input  wire logic               thermal_shutdown,
	input  wire logic               supply_low_lockout,
	input  wire logic               supply_high_lockout,
	// Status and settings
	output logic                    serial_access_en,
	output logic [6:0]              target_address,
	output logic [11:0]             fsw_khz,
	output logic [7:0]              output_setpoint_code,
	output logic [1:0]              setpoint_range_select,
	output logic [1:0]              soft_start_duration_select,
	output logic [1:0]              dvs_slew_select,
	output logic [22:0]             vref_q,
	output logic                    soft_start_active,
	output logic                    dvs_active,
	output logic                    ramp_done,
	output logic                    converter_on,
	output logic                    load_line_active,
	// Switching control
	output bsr_pkg::bsr_mode_t      mode,
	output logic [7:0]              ssc_offset_permil,
	output logic                    output_discharge
);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic [22:0] target_of(input logic [7:0] code, input logic [1:0] rng);
		logic [22:0] step;
		step = bsr_pkg::STEP_WIDE_Q;
		if (rng == bsr_pkg::RANGE_FINE) begin
			step = bsr_pkg::STEP_FINE_Q;
		end else if (rng == bsr_pkg::RANGE_MID) begin
			step = bsr_pkg::STEP_MID_Q;
		end
		return bsr_pkg::OUTPUT_SETPOINT_CODE_BASE_Q + {15'h0000, code} * step;
	endfunction : target_of

	// Per-cycle share of the target with 24 fraction bits; truncating it would stretch the ramp
	function automatic logic [31:0] ss_step_of(input logic [22:0] tgt, input logic [1:0] sel);
		logic [31:0] recip;
		unique case (sel)
			2'h0: recip = bsr_pkg::SS_T0_RECIP;
			2'h1: recip = bsr_pkg::SS_T1_RECIP;
			2'h2: recip = bsr_pkg::SS_T2_RECIP;
			2'h3: recip = bsr_pkg::SS_T3_RECIP;
		endcase
		return {9'h000, tgt} * recip;
	endfunction : ss_step_of

	function automatic logic [22:0] slew_of(input logic [1:0] sel);
		logic [22:0] r;
		unique case (sel)
			2'h0: r = bsr_pkg::SLEW_0_Q;
			2'h1: r = bsr_pkg::SLEW_1_Q;
			2'h2: r = bsr_pkg::SLEW_2_Q;
			2'h3: r = bsr_pkg::SLEW_3_Q;
		endcase
		return r;
	endfunction : slew_of

	// ****************************************
	// Strap decoders
	// ****************************************
	bsr_pkg::bsr_strap_t fstrap;
	bsr_pkg::bsr_strap_t vstrap;

	bsr_strap_decoder u_fstrap (
		.clk       (clk),
		.reset     (reset),
		.pin_level (fstrap_level),
		.strap     (fstrap)
	);

	bsr_strap_decoder u_vstrap (
		.clk       (clk),
		.reset     (reset),
		.pin_level (vstrap_level),
		.strap     (vstrap)
	);

	// ****************************************
	// Control state
	// ****************************************
	bsr_pkg::bsr_ctrl_state_t s_reg;
	bsr_pkg::bsr_ctrl_state_t s_next;
	logic                     conv_en;
	logic                     init_done;
	logic [22:0]              live_tgt;
	logic [22:0]              cap_tgt;
	logic [31:0]              ss_step;
	logic [46:0]              ss_acc;
	logic [22:0]              slew;
	logic                     forced;
	logic                     sync_in_use;

	assign init_done   = (s_reg.phase != bsr_pkg::ph_init);
	assign conv_en     = init_done && en_pin_in && switching_enable_bit && !thermal_shutdown
		&& !supply_low_lockout && !supply_high_lockout;
	assign live_tgt    = target_of(s_reg.setpoint, s_reg.range_act);
	assign cap_tgt     = target_of(s_reg.cap_code, s_reg.cap_range);
	assign ss_step     = ss_step_of(cap_tgt, s_reg.cap_ss);
	assign ss_acc      = {s_reg.ref_q, s_reg.ref_frac} + {15'h0000, ss_step};
	assign slew        = slew_of(s_reg.slew_sel);
	assign sync_in_use = sync_clock_valid || stacked_secondary;
	assign forced      = mode_pin_level || forced_pwm_bit || sync_in_use;

	always_comb begin
		s_next           = s_reg;
		s_next.load_line = load_line_enable;

		// Writes are stored at once; the soft-start ramp only sees captured copies
		if (init_done) begin
			if (host_wr.range_wr) begin
				s_next.range_prog = host_wr.range;
			end
			if (host_wr.setpoint_wr) begin
				s_next.setpoint  = host_wr.setpoint;
				// Same-cycle range write is applied too
				s_next.range_act = host_wr.range_wr ? host_wr.range : s_reg.range_prog;
			end
			if (host_wr.ss_wr) begin
				s_next.ss_sel = host_wr.ss_sel;
			end
			if (host_wr.slew_wr) begin
				s_next.slew_sel = host_wr.slew_sel;
			end
		end

		unique case (s_reg.phase)
			bsr_pkg::ph_init: begin
				if (fstrap.done && vstrap.done) begin
					s_next.fsw_khz    = bsr_pkg::FSTRAP_KHZ[fstrap.code];
					s_next.setpoint   = bsr_pkg::VSTRAP_CODE[vstrap.code];
					s_next.address    = bsr_pkg::VSTRAP_ADDR[vstrap.code];
					s_next.range_prog = bsr_pkg::RANGE_RESET;
					s_next.range_act  = bsr_pkg::RANGE_RESET;
					s_next.ss_sel     = bsr_pkg::SS_RESET;
					s_next.slew_sel   = bsr_pkg::SLEW_RESET;
					s_next.phase      = bsr_pkg::ph_off;
				end
			end
			bsr_pkg::ph_off: begin
				s_next.ref_q    = 23'h000000;
				s_next.ref_frac = 24'h000000;
				if (conv_en) begin
					// Settings written while disabled are picked up here
					s_next.cap_code     = s_reg.setpoint;
					s_next.cap_range    = s_reg.range_act;
					s_next.cap_ss       = s_reg.ss_sel;
					s_next.enabled_once = 1'b1;
					s_next.phase        = bsr_pkg::ph_soft;
				end
			end
			bsr_pkg::ph_soft: begin
				if (!conv_en) begin
					s_next.phase = bsr_pkg::ph_off;
				end else if (ss_acc[46:24] >= cap_tgt) begin
					s_next.ref_q = cap_tgt;
					s_next.phase = bsr_pkg::ph_run;
				end else begin
					s_next.ref_q    = ss_acc[46:24];
					s_next.ref_frac = ss_acc[23:0];
				end
			end
			bsr_pkg::ph_run: begin
				if (!conv_en) begin
					s_next.phase = bsr_pkg::ph_off;
				end else if (live_tgt > s_reg.ref_q) begin
					if (live_tgt - s_reg.ref_q <= slew) begin
						s_next.ref_q = live_tgt;
					end else begin
						s_next.ref_q = s_reg.ref_q + slew;
					end
				end else if (live_tgt < s_reg.ref_q) begin
					if (s_reg.ref_q - live_tgt <= slew) begin
						s_next.ref_q = live_tgt;
					end else begin
						s_next.ref_q = s_reg.ref_q - slew;
					end
				end
			end
		endcase

		// Triangle sweep; restarts from centre whenever the sweep is off
		if (mode.ssc_active) begin
			if (s_reg.ssc_cnt == 8'(bsr_pkg::SSC_STEP_CYC - 1)) begin
				s_next.ssc_cnt = 8'h00;
				if (s_reg.ssc_up) begin
					if (s_reg.ssc_tri == bsr_pkg::SSC_SPAN) begin
						s_next.ssc_up  = 1'b0;
						s_next.ssc_tri = s_reg.ssc_tri - 8'h01;
					end else begin
						s_next.ssc_tri = s_reg.ssc_tri + 8'h01;
					end
				end else begin
					if (s_reg.ssc_tri == bsr_pkg::SSC_FLOOR) begin
						s_next.ssc_up  = 1'b1;
						s_next.ssc_tri = s_reg.ssc_tri + 8'h01;
					end else begin
						s_next.ssc_tri = s_reg.ssc_tri - 8'h01;
					end
				end
			end else begin
				s_next.ssc_cnt = s_reg.ssc_cnt + 8'h01;
			end
		end else begin
			s_next.ssc_cnt = 8'h00;
			s_next.ssc_tri = 8'h00;
			s_next.ssc_up  = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '{
				phase:        bsr_pkg::ph_init,
				setpoint:     8'h00,
				range_prog:   bsr_pkg::RANGE_RESET,
				range_act:    bsr_pkg::RANGE_RESET,
				ss_sel:       bsr_pkg::SS_RESET,
				slew_sel:     bsr_pkg::SLEW_RESET,
				cap_code:     8'h00,
				cap_range:    bsr_pkg::RANGE_RESET,
				cap_ss:       bsr_pkg::SS_RESET,
				ref_q:        23'h000000,
				ref_frac:     24'h000000,
				address:      7'h00,
				fsw_khz:      12'h000,
				enabled_once: 1'b0,
				ssc_tri:      8'h00,
				ssc_up:       1'b1,
				ssc_cnt:      8'h00,
				load_line:    1'b0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Enable is held low through initialization only; faults are left to pins outside
	assign en_pin_out          = 1'b0;
	assign en_pin_oe           = !init_done;
	assign serial_access_en    = init_done;
	assign fstrap_probe_first  = fstrap.probe_first;
	assign fstrap_probe_second = fstrap.probe_second;
	assign vstrap_probe_first  = vstrap.probe_first;
	assign vstrap_probe_second = vstrap.probe_second;

	assign target_address             = s_reg.address;
	assign fsw_khz                    = s_reg.fsw_khz;
	assign output_setpoint_code       = s_reg.setpoint;
	assign setpoint_range_select      = s_reg.range_prog;
	assign soft_start_duration_select = s_reg.ss_sel;
	assign dvs_slew_select            = s_reg.slew_sel;
	assign vref_q                     = s_reg.ref_q;
	assign load_line_active           = s_reg.load_line;
	assign soft_start_active = (s_reg.phase == bsr_pkg::ph_soft);
	assign converter_on      = (s_reg.phase == bsr_pkg::ph_soft) || (s_reg.phase == bsr_pkg::ph_run);
	assign dvs_active        = (s_reg.phase == bsr_pkg::ph_run) && (s_reg.ref_q != live_tgt);
	assign ramp_done         = (s_reg.phase == bsr_pkg::ph_run) && (s_reg.ref_q == live_tgt);

	// Start-up always allows light-load switching, whatever forces PWM
	assign mode.dcm_allowed = soft_start_active || !forced;
	assign mode.forced_pwm  = forced && !soft_start_active;
	assign mode.power_save  = !forced;
	assign mode.sync_lock   = sync_in_use;
	assign mode.ssc_active  = spread_spectrum_enable && forced && !sync_in_use;
	assign ssc_offset_permil = s_reg.ssc_tri;

	// Discharge stays off until the first enable after power-up
	assign output_discharge = discharge_enable && s_reg.enabled_once && (!en_pin_in
		|| !switching_enable_bit || thermal_shutdown || supply_low_lockout
		|| supply_high_lockout);

endmodule : bsr_setpoint_ramp_control

`default_nettype wire

// ==== bench/bsr_setpoint_ramp_control_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port checker
// ****************************************
module bsr_sva (
	// Clock and reset
	input wire logic               clk,
	input wire logic               reset,
	// Pins and host bits
	input wire logic               en_pin_in,
	input wire logic               en_pin_oe,
	input wire logic               fstrap_probe_first,
	input wire logic               fstrap_probe_second,
	input wire bsr_pkg::bsr_host_wr_t host_wr,
	input wire logic               forced_pwm_bit,
	input wire logic               spread_spectrum_enable,
	input wire logic               discharge_enable,
	input wire logic               switching_enable_bit,
	input wire logic               mode_pin_level,
	input wire logic               sync_clock_valid,
	input wire logic               thermal_shutdown,
	input wire logic               supply_low_lockout,
	input wire logic               supply_high_lockout,
	// Status
	input wire logic               serial_access_en,
	input wire logic [6:0]         target_address,
	input wire logic [11:0]        fsw_khz,
	input wire logic [7:0]         output_setpoint_code,
	input wire logic [22:0]        vref_q,
	input wire logic               soft_start_active,
	input wire bsr_pkg::bsr_mode_t mode,
	input wire logic [7:0]         ssc_offset_permil,
	input wire logic               output_discharge
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Set at the first enable request; discharge stays barred before it
	logic seen_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			seen_reg <= 1'b0;
		end else if (en_pin_in && switching_enable_bit && serial_access_en) begin
			seen_reg <= 1'b1;
		end
	end

	sequence s_settled;
		serial_access_en ##1 serial_access_en;
	endsequence
	sequence s_soft_run;
		soft_start_active ##1 soft_start_active;
	endsequence

	a_probe_excl: assert property (!(fstrap_probe_first && fstrap_probe_second))
		else $error("both strap probes closed");
	a_init_release: assert property (en_pin_oe != serial_access_en)
		else $error("enable release and serial access disagree");
	a_strap_hold: assert property (s_settled |-> $stable(fsw_khz) && $stable(target_address))
		else $error("strap result changed after init");
	a_soft_dcm: assert property (soft_start_active |-> mode.dcm_allowed && !mode.forced_pwm)
		else $error("forced switching during soft start");
	a_forced_pwm_operation_cause: assert property (serial_access_en && !soft_start_active
		&& (mode_pin_level || forced_pwm_bit || sync_clock_valid) |-> mode.forced_pwm)
		else $error("forced pwm not selected");
	a_ssc_gate: assert property (mode.ssc_active |->
		spread_spectrum_enable && (mode_pin_level || forced_pwm_bit) && !sync_clock_valid)
		else $error("spread spectrum active without its conditions");
	a_ssc_span: assert property ($signed(ssc_offset_permil) >= 8'sh9C
		&& $signed(ssc_offset_permil) <= 8'sh64)
		else $error("spread offset beyond ten percent");
	a_disch_cause: assert property (output_discharge |-> discharge_enable && (!en_pin_in
		|| !switching_enable_bit || thermal_shutdown || supply_low_lockout
		|| supply_high_lockout))
		else $error("discharge without cause");
	a_disch_first: assert property (!seen_reg |-> !output_discharge)
		else $error("discharge before first enable");
	a_ramp_mono: assert property (s_soft_run |-> vref_q >= $past(vref_q))
		else $error("soft start reference fell");
	a_sp_store: assert property (host_wr.setpoint_wr && serial_access_en |=>
		output_setpoint_code == $past(host_wr.setpoint))
		else $error("setpoint write not stored");
endmodule : bsr_sva

bind bsr_setpoint_ramp_control bsr_sva i_bsr_sva (.*);

`default_nettype wire

// ==== bench/bsr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host write model
// ****************************************
module bsr_host_model (
	// Clock
	input wire logic                  clk,
	// Writes toward the block
	output var bsr_pkg::bsr_host_wr_t host_wr
);
	initial host_wr = '0;

	// One-cycle strobe; data turns over afterwards so stale values are never trusted
	task automatic put(input logic [3:0] k, input logic [7:0] v);
		@(posedge clk);
		#1;
		host_wr = {k[0], v, k[1], v[1:0], k[2], v[1:0], k[3], v[1:0]};
		@(posedge clk);
		#1;
		host_wr = {1'b0, ~v, 1'b0, ~v[1:0], 1'b0, ~v[1:0], 1'b0, ~v[1:0]};
	endtask : put
endmodule : bsr_host_model

`default_nettype wire

// ==== bench/bsr_setpoint_ramp_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module bsr_setpoint_ramp_control_bench;
	localparam logic [11:0] FK [4] = '{12'h8CA, 12'h5DC, 12'hBB8, 12'h9C4};
	localparam logic [7:0]  VC [4] = '{8'h46, 8'h50, 8'h24, 8'h5F};
	localparam logic [6:0]  VA [4] = '{7'h45, 7'h44, 7'h47, 7'h46};
	logic clk, reset, en_drv, en_pin_in, en_pin_out, en_pin_oe;
	logic fstrap_level, fstrap_probe_first, fstrap_probe_second;
	logic vstrap_level, vstrap_probe_first, vstrap_probe_second;
	logic forced_pwm_bit, spread_spectrum_enable, discharge_enable;
	logic switching_enable_bit, load_line_enable, mode_pin_level, sync_clock_valid;
	logic serial_access_en, soft_start_active, dvs_active, ramp_done, converter_on;
	logic load_line_active, output_discharge, stacked_secondary, thermal_shutdown;
	logic supply_low_lockout, supply_high_lockout;
	logic [6:0] target_address;
	logic [11:0] fsw_khz;
	logic [7:0] output_setpoint_code, ssc_offset_permil;
	logic [1:0] setpoint_range_select, soft_start_duration_select, dvs_slew_select;
	logic [1:0] fcode, vcode;
	logic [22:0] vref_q;
	bsr_pkg::bsr_host_wr_t host_wr;
	bsr_pkg::bsr_mode_t mode;
	int n_errors = 0;
	int compares = 0;

	// Strap pins: open probes show the upper bit, a closed probe the lower bit
	assign fstrap_level = (fstrap_probe_first || fstrap_probe_second) ? fcode[0] : fcode[1];
	assign vstrap_level = (vstrap_probe_first || vstrap_probe_second) ? vcode[0] : vcode[1];
	assign en_pin_in = en_drv && !en_pin_oe;

	bsr_host_model i_bsr_host_model (.clk, .host_wr);
	bsr_setpoint_ramp_control i_bsr_setpoint_ramp_control (.*);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [22:0] tgt(input logic [7:0] c, input logic [1:0] r);
		return 23'h186A00 + c * (r == 2'h0 ? 23'h001388 : r == 2'h1 ? 23'h002710 : 23'h004E20);
	endfunction : tgt

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// Bounded wait: 0 init done, 1 soft start over, 2 ramp done
	task automatic await(input int w, input int lim, output int n);
		n = 0;
		while (!(w == 0 ? serial_access_en === 1'b1 : w == 1 ? soft_start_active === 1'b0
			: ramp_done === 1'b1)) begin
			cyc(1);
			n++;
			if (n > lim) begin
				n_errors++;
				$display("CHECK FAILED wait %0d expected done seen timeout", w);
				complete_run();
			end
		end
	endtask : await

	initial begin
		int n, d, e;
		logic [7:0] c1, c2, c3;
		logic [1:0] s;
		logic [3:0] m;
		{reset, en_drv, forced_pwm_bit, spread_spectrum_enable, load_line_enable} = 5'h10;
		{stacked_secondary, thermal_shutdown, supply_low_lockout, supply_high_lockout,
			mode_pin_level, sync_clock_valid, discharge_enable, switching_enable_bit} = 8'h03;
		{fcode, vcode} = 4'h0;
		n = $urandom(32'h161975C9);
		for (int k = 0; k < 4; k++) begin
			{fcode, vcode, reset} = {2'(k), 2'(3 - k), 1'b1};
			cyc(2);
			reset = 1'b0;
			await(0, 100, n);
			chk("fsw_khz", FK[k], fsw_khz);
			chk("setpoint", VC[3 - k], output_setpoint_code);
			chk("address", VA[3 - k], target_address);
		end
		chk("defaults", 6'h2A, {setpoint_range_select, soft_start_duration_select,
			dvs_slew_select});
		fcode = 2'h0;
		cyc(3);
		chk("fsw_held", FK[3], fsw_khz);
		chk("discharge", 1'b0, output_discharge);
		load_line_enable = 1'b1;
		cyc(2);
		chk("load_line", 1'b1, load_line_active);
		$display("test straps done");
		c1 = 8'($urandom_range(8'h10, 8'h30));
		c2 = 8'($urandom_range(8'h10, 8'h30));
		c3 = 8'($urandom_range(8'h10, 8'h30));
		s = 2'($urandom_range(2'h0, 2'h3));
		i_bsr_host_model.put(4'h4, 8'h00);
		i_bsr_host_model.put(4'h8, {6'h00, s});
		i_bsr_host_model.put(4'h1, c1);
		chk("selects", {4'h0, s}, {soft_start_duration_select, dvs_slew_select});
		en_drv = 1'b1;
		cyc(5);
		chk("soft_dcm", 2'h3, {soft_start_active, mode.dcm_allowed});
		i_bsr_host_model.put(4'h1, c2);
		await(1, 52000, n);
		chk("soft_len", 1'b1, n > 48900 && n < 49995);
		chk("vref_soft", tgt(c1, 2'h2), vref_q);
		await(2, 40000, n);
		chk("vref_dvs", tgt(c2, 2'h2), vref_q);
		d = c1 > c2 ? (c1 - c2) * 20000 : (c2 - c1) * 20000;
		e = s == 2'h0 ? 400 : s == 2'h1 ? 200 : s == 2'h2 ? 50 : 20;
		e = (d + e - 1) / e;
		chk("dvs_len", 1'b1, n + 3 >= e && n <= e + 3);
		$display("test ramps done");
		i_bsr_host_model.put(4'hA, 8'h00);
		cyc(10);
		chk("range_wait", {2'h0, tgt(c2, 2'h2)}, {setpoint_range_select, vref_q});
		i_bsr_host_model.put(4'h1, c3);
		cyc(3);
		await(2, 3000, n);
		chk("vref_fine", tgt(c3, 2'h0), vref_q);
		$display("test range done");
		for (int i = 0; i < 16; i++) begin
			m = 4'(i);
			{spread_spectrum_enable, sync_clock_valid, forced_pwm_bit, mode_pin_level} = m;
			cyc(2);
			chk("forced_pwm", m[0] | m[1] | m[2], mode.forced_pwm);
			chk("power_save", !(m[0] | m[1] | m[2]), mode.power_save);
			chk("sync_lock", m[2], mode.sync_lock);
			chk("ssc_active", m[3] & (m[0] | m[1]) & !m[2], mode.ssc_active);
		end
		sync_clock_valid = 1'b0;
		stacked_secondary = 1'b1;
		cyc(2);
		chk("stacked", 2'h2, {mode.sync_lock, mode.ssc_active});
		stacked_secondary = 1'b0;
		cyc(300);
		$display("test modes done");
		en_drv = 1'b0;
		cyc(3);
		chk("disch_en_low", 2'h2, {output_discharge, converter_on});
		discharge_enable = 1'b0;
		cyc(2);
		chk("disch_off", 1'b0, output_discharge);
		{en_drv, switching_enable_bit, discharge_enable} = 3'h5;
		cyc(2);
		chk("disch_switching_enable_bit", 1'b1, output_discharge);
		{switching_enable_bit, thermal_shutdown} = 2'h3;
		cyc(2);
		chk("disch_fault", 1'b1, output_discharge);
		$display("test discharge done");
		complete_run();
	end
endmodule : bsr_setpoint_ramp_control_bench

`default_nettype wire
